// ===== bench/epr_spi_eeprom_assertions.sv
// Pin-level checker for the serial EEPROM front end
`timescale 1ns/1ps
`default_nettype none
module epr_spi_eeprom_checker
    import epr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Serial pins and power state
    input wire logic spiClk,
    input wire logic chipSelN,
    input wire logic dataIn,
    input wire logic holdN,
    input wire logic writeProtN,
    input wire logic dataOut,
    input wire logic dataOutEn,
    input wire logic standby
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic armed;
    // Set once select has been seen high
    always_ff @(posedge sys_clk) begin
        if (reset)
            armed <= 1'b0;
        else if (chipSelN)
            armed <= 1'b1;
    end
    chk_float_deselect: assert property (chipSelN [*4] |-> !dataOutEn)
        else $error("output enabled while deselected");
    chk_active_selected: assert property ((armed && !chipSelN) [*6] |-> !standby)
        else $error("standby while selected");
    chk_standby_deselected: assert property ($rose(standby) |->
        $past(chipSelN, 2) || $past(chipSelN, 3))
        else $error("standby entered while selected");
    chk_out_after_fall: assert property (dataOutEn && $changed(dataOut) |->
        !$past(spiClk, 2))
        else $error("output changed outside low clock phase");
    chk_hold_float: assert property ((!holdN && !spiClk) [*5] |-> !dataOutEn)
        else $error("output driven while paused");
    chk_arm_first: assert property (!armed |-> !dataOutEn)
        else $error("output driven before select armed");
    chk_enable_cause: assert property ($rose(dataOutEn) |->
        !$past(spiClk, 2) && !chipSelN && holdN)
        else $error("output enable without clock fall");
    chk_reset_state: assert property ($fell(reset) |-> standby && !dataOutEn)
        else $error("wrong state after reset");
endmodule
bind epr_spi_eeprom epr_spi_eeprom_checker u_chk (.sys_clk, .reset, .spiClk, .chipSelN, .dataIn,
    .holdN, .writeProtN, .dataOut, .dataOutEn, .standby);
`default_nettype wire

// ===== bench/epr_spi_master.sv
// Mode 0 serial bus master model
`timescale 1ns/1ps
`default_nettype none
module epr_spi_master (
    // Clock
    input  wire logic sys_clk,
    // Serial pins
    output logic      spiClk,
    output logic      chipSelN,
    output logic      dataIn,
    output logic      holdN,
    input  wire logic dataOut
);
    // Select already low at power-up
    initial begin
        spiClk = 1'b0;
        chipSelN = 1'b0;
        dataIn = 1'b0;
        holdN = 1'b1;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic sel();
        chipSelN <= 1'b0;
        cyc(4);
    endtask
    task automatic xb(input logic [7:0] b, input int nb, input int hp, output logic [7:0] r);
        r = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            dataIn <= b[i];
            if (i == hp) begin
                holdN <= 1'b0;
                cyc(6);
                holdN <= 1'b1;
            end
            cyc(4);
            spiClk <= 1'b1;
            cyc(4);
            r[i] = dataOut;
            spiClk <= 1'b0;
        end
    endtask
    task automatic desel();
        cyc(4);
        chipSelN <= 1'b1;
        cyc(8);
    endtask
    task automatic hold_desel();
        holdN <= 1'b0;
        cyc(6);
        chipSelN <= 1'b1;
        cyc(8);
        holdN <= 1'b1;
        cyc(4);
    endtask
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Command-level bench for the serial EEPROM front end
`timescale 1ns/1ps
`default_nettype none
module testbench
    import epr_pkg::*;
;
    logic       sys_clk = 1'b0;
    logic       reset = 1'b1;
    logic       writeProtN = 1'b1;
    logic       spiClk, chipSelN, dataIn, holdN, dataOut, dataOutEn, standby;
    logic [7:0] r;
    logic       miso;
    int         num_errors = 0;
    int         check_count = 0;
    int         cycles = 0;
    always #50 sys_clk = ~sys_clk;
    epr_spi_eeprom #(.PROG_CYCLES(300)) DUT (.sys_clk, .reset, .spiClk, .chipSelN, .dataIn,
        .holdN, .writeProtN, .dataOut, .dataOutEn, .standby);
    // Released line reads back inverted so a floating output is caught
    assign miso = dataOutEn ? dataOut : !dataOut;
    epr_spi_master M (.sys_clk, .spiClk, .chipSelN, .dataIn, .holdN, .dataOut(miso));
    task automatic give_verdict();
        if (num_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic frm(input logic [47:0] w, input int nbits, input int hp);
        M.sel();
        for (int i = 0; i < nbits; i += 8)
            M.xb(w[47-i -: 8], (nbits - i > 8) ? 8 : nbits - i, hp, r);
        M.desel();
    endtask
    task automatic st(input logic [7:0] exp);
        frm({OPC_STATUS_FETCH, 40'h0}, 16, 8);
        chk(r, exp);
    endtask
    task automatic wen();
        frm({OPC_ENABLE_WRITES, 40'h0}, 8, 8);
    endtask
    task automatic waitready();
        for (int k = 0; k < 10; k++) begin
            frm({OPC_STATUS_FETCH, 40'h0}, 16, 8);
            if (r[0] === 1'b0)
                break;
        end
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (4) @(posedge sys_clk);
        M.xb(OPC_ENABLE_WRITES, 8, 8, r);
        M.desel();
        st(8'h00);
        wen();
        st(8'h02);
        frm({OPC_DISABLE_WRITES, 40'h0}, 8, 8);
        st(8'h00);
        frm({OPC_ARRAY_WRITE, 16'h0010, 8'ha5, 8'h3c, 8'h00}, 40, 8);
        st(8'h00);
        wen();
        frm({OPC_ARRAY_WRITE, 16'h0010, 8'ha5, 8'h3c, 8'h00}, 40, 8);
        st(8'h03);
        chk({7'h00, standby}, 8'h00);
        waitready();
        st(8'h00);
        chk({7'h00, standby}, 8'h01);
        frm({OPC_ARRAY_READ, 16'h0010, 24'h0}, 40, 8);
        chk(r, 8'h3c);
        frm({OPC_ARRAY_READ, 16'h0010, 24'h0}, 32, 5);
        chk(r, 8'ha5);
        wen();
        frm({OPC_ARRAY_WRITE, 16'h0020, 8'h5a, 8'hff, 8'h00}, 43, 8);
        st(8'h02);
        M.sel();
        for (int k = 0; k < 4; k++)
            M.xb((k == 0) ? OPC_ARRAY_WRITE : 8'h30, 8, 8, r);
        M.hold_desel();
        st(8'h02);
        frm({OPC_IDPAGE_STORE, 16'h0005, 8'h77, 16'h0}, 32, 8);
        waitready();
        frm({OPC_IDPAGE_FETCH, 16'h0005, 24'h0}, 32, 8);
        chk(r, 8'h77);
        wen();
        frm({OPC_STATUS_STORE, 8'h8c, 32'h0}, 16, 8);
        waitready();
        st(8'h8c);
        writeProtN <= 1'b0;
        wen();
        frm({OPC_STATUS_STORE, 8'h00, 32'h0}, 16, 8);
        st(8'h8e);
        frm({OPC_ARRAY_WRITE, 16'h0010, 8'h11, 16'h0}, 32, 8);
        st(8'h8e);
        frm({OPC_ARRAY_READ, 16'h0010, 24'h0}, 32, 8);
        chk(r, 8'ha5);
        frm({OPC_IDPAGE_STORE, 16'h0005, 8'h00, 16'h0}, 32, 8);
        st(8'h8e);
        frm({OPC_IDPAGE_FETCH, 16'h0005, 24'h0}, 32, 8);
        chk(r, 8'h77);
        give_verdict();
    end
endmodule
`default_nettype wire

// ===== rtl/epr_byte_store.sv
// Byte array and identification page with registered read data
`timescale 1ns/1ps
`default_nettype none
module epr_byte_store
    import epr_pkg::*;
(
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          reset,
    // Access port
    input  wire epr_mem_req_s  req,
    output logic [BYTE_W-1:0]  rdData
);
    logic [BYTE_W-1:0] mainArr [ARRAY_BYTES];
    logic [BYTE_W-1:0] idArr   [ID_BYTES];

    always_ff @(posedge sys_clk) begin
        if (req.wr && !req.idSel) begin
            mainArr[req.addr] <= req.wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (req.wr && req.idSel) begin
            idArr[req.addr[ID_ADDR_W-1:0]] <= req.wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdData <= 8'h00;
        end else if (req.rd) begin
            rdData <= req.idSel ? idArr[req.addr[ID_ADDR_W-1:0]] : mainArr[req.addr];
        end
    end
endmodule
`default_nettype wire

// ===== rtl/epr_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module epr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic             flush,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0]    wrPtr;
    logic [PW-1:0]    rdPtr;
    logic [PW:0]      count;
    logic             push;
    logic             pop;

    assign inReady  = (count != DEPTH[PW:0]);
    assign outValid = (count != '0);
    assign outData  = store[rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            store[wrPtr] <= inData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || flush) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== rtl/epr_pkg.sv
// Shared constants and types for the serial EEPROM front end
package epr_pkg;

    // Timing
    localparam int CLK_PERIOD_NS       = 100;
    localparam int PROG_TIME_NS        = 4000000;
    localparam int PROG_CYCLES_DEFAULT = PROG_TIME_NS / CLK_PERIOD_NS;

    // Geometry
    localparam int BYTE_W      = 8;
    localparam int ADDR_W      = 16;
    localparam int ARRAY_BYTES = 65536;
    localparam int PAGE_BYTES  = 128;
    localparam int PAGE_COUNT  = 512;
    localparam int ID_BYTES    = 128;
    localparam int ID_ADDR_W   = 7;
    localparam int FIFO_DEPTH  = 8;
    localparam int LOCK_SEL_BIT = 10;

    // Instruction codes
    localparam logic [7:0] OPC_ENABLE_WRITES  = 8'h06;
    localparam logic [7:0] OPC_DISABLE_WRITES = 8'h04;
    localparam logic [7:0] OPC_STATUS_FETCH   = 8'h05;
    localparam logic [7:0] OPC_STATUS_STORE   = 8'h01;
    localparam logic [7:0] OPC_ARRAY_READ     = 8'h03;
    localparam logic [7:0] OPC_ARRAY_WRITE    = 8'h02;
    localparam logic [7:0] OPC_IDPAGE_FETCH   = 8'h83;
    localparam logic [7:0] OPC_IDPAGE_STORE   = 8'h82;

    // Block protection codes and bounds
    localparam logic [1:0]  BP_NONE          = 2'b00;
    localparam logic [1:0]  BP_QUARTER       = 2'b01;
    localparam logic [1:0]  BP_HALF          = 2'b10;
    localparam logic [1:0]  BP_ALL           = 2'b11;
    localparam logic [15:0] PROT_QUARTER_BASE = 16'hc000;
    localparam logic [15:0] PROT_HALF_BASE    = 16'h8000;

    // Power-up values of the non-volatile bits
    localparam logic [1:0] BP_RESET  = 2'b00;
    localparam logic       SWD_RESET = 1'b0;

    typedef enum logic [2:0] {
        PH_OPCODE, PH_ADDR_HI, PH_ADDR_LO, PH_TAKE, PH_GIVE, PH_IGNORE
    } epr_phase_e;

    typedef enum logic [3:0] {
        OP_NONE, OP_WEN, OP_WDIS, OP_STATUS, OP_ARRAY, OP_IDPAGE,
        OP_FETCH_STATUS, OP_FETCH_ARRAY, OP_FETCH_ID
    } epr_op_e;

    typedef enum logic [1:0] {EN_IDLE, EN_PROGRAM, EN_SETTLE} epr_engine_e;

    // Status register layout, msb first
    typedef struct packed {
        logic       statusWriteDisable;
        logic [2:0] unused;
        logic       blockProtectHi;
        logic       blockProtectLo;
        logic       writeEnableLatch;
        logic       busyFlag;
    } epr_status_s;

    typedef struct packed {
        logic       spiClk;
        logic       chipSelN;
        logic       holdN;
        logic       writeProtN;
        logic       dataIn;
    } epr_pins_s;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        idSel;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } epr_mem_req_s;

endpackage

// ===== rtl/epr_spi_eeprom.sv
// Serial EEPROM front end: pin sampling, framing, decode, protection
//
// Overview of operation
// - Output bits change after falling clock edges, msb first; floated otherwise.
// - Input bits sampled on rising clock edges, msb first per byte.
// - Select low starts a frame; select high ends it and floats output.
// - Modes 0 and 3 both sample rising, drive falling; idle level differs.
// - Hold low with clock low pauses; output floats, inputs ignored.
// - Hold high with clock low ends the pause; transfer resumes.
// - Deselect during a pause abandons the transfer and resets decoding.
// - After power-up, only a falling select edge starts a frame.
// - Writes need latch set, whole bytes, data, and byte-aligned deselect.
// - Deselect off a byte boundary discards a write command.
// - Reads keep shifting data out until select rises.
// - Status bits 6, 5 and 4 always read zero.
// - Busy flag is one from the committing deselect until the write cycle ends.
// - With the enable latch clear, write commands are ignored.
// - Latch set by enable; cleared by disable, write completion, power-up.
// - Block-protect bits are non-volatile and change only by status store.
// - Protect code selects none, upper quarter, upper half, or everything.
// - Standby only when no frame is open and no write cycle runs.
// - Array holds 65536 bytes as 512 pages of 128 bytes.
// - Separate 128-byte identification page, readable and writable.
// - Write-protect pin guards the status register.
// - Disable bit set and protect pin low discards status stores.
// - First byte is the instruction; unknown codes idle until deselect.
// - Array and page commands carry a two-byte address, high byte first.
`timescale 1ns/1ps
`default_nettype none
module epr_spi_eeprom
    import epr_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYCLES_DEFAULT
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // Serial pins from the master
    input  wire logic spiClk,
    input  wire logic chipSelN,
    input  wire logic dataIn,
    input  wire logic holdN,
    input  wire logic writeProtN,
    // Serial output pin
    output logic      dataOut,
    output logic      dataOutEn,
    // Power state
    output logic      standby
);
    epr_pins_s    pinsRaw;
    epr_pins_s    pinMeta;
    epr_pins_s    pinSync;
    epr_pins_s    pinPrev;

    logic         inFrame;
    logic         paused;
    logic         clkRise;
    logic         clkFall;
    logic         csFall;
    logic         csRise;

    logic [2:0]   bitCnt;
    logic [7:0]   shiftIn;
    logic [7:0]   rxByte;
    logic         byteDone;
    logic         boundary;

    epr_phase_e   phase;
    epr_phase_e   next_phase;
    epr_op_e      op;
    epr_op_e      next_op;
    logic [15:0]  addr;
    logic [15:0]  addrNext;
    logic         gotData;
    logic [7:0]   stagedByte;

    logic         opIsFetch;
    logic         issueGive;
    logic         loadPending;
    logic [7:0]   outShift;
    logic [7:0]   outByte;
    logic         outLive;

    logic         write_enable_latch;
    logic [1:0]   bp;
    logic         swd;
    epr_status_s  statusByte;

    logic         validEnd;
    logic         blocked;
    logic         commitWrite;
    logic         discard;

    epr_engine_e  engine;
    epr_op_e      progOp;
    logic [15:0]  progAddr;
    logic         progLock;
    logic [7:0]   progStatus;
    logic [31:0]  timer;
    logic         busy;
    logic         cycleDone;

    logic         fifoInValid;
    logic         fifoInReady;
    logic         fifoOutValid;
    logic         fifoOutReady;
    logic [7:0]   fifoOutData;
    epr_mem_req_s memReq;
    logic [7:0]   memQ;

    assign pinsRaw = '{spiClk: spiClk, chipSelN: chipSelN, holdN: holdN,
                       writeProtN: writeProtN, dataIn: dataIn};

    // Two-stage synchroniser for every pin
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pinMeta <= '0;
            pinSync <= '0;
        end else begin
            pinMeta <= pinsRaw;
            pinSync <= pinMeta;
        end
    end

    // Previous levels start low so a select held low is no falling edge
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pinPrev <= '0;
        end else begin
            pinPrev <= pinSync;
        end
    end

    assign csFall = !pinSync.chipSelN && pinPrev.chipSelN;
    assign csRise = pinSync.chipSelN && !pinPrev.chipSelN;

    assign clkRise = inFrame && !paused && pinSync.spiClk && !pinPrev.spiClk;
    assign clkFall = inFrame && !paused && !pinSync.spiClk && pinPrev.spiClk;

    always_ff @(posedge sys_clk) begin
        if (reset || csRise) begin
            inFrame <= 1'b0;
        end else if (csFall) begin
            inFrame <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || csRise || !inFrame) begin
            paused <= 1'b0;
        end else if (!pinSync.holdN && !pinSync.spiClk) begin
            paused <= 1'b1;
        end else if (pinSync.holdN && !pinSync.spiClk) begin
            paused <= 1'b0;
        end
    end

    assign rxByte   = {shiftIn[6:0], pinSync.dataIn};
    assign byteDone = clkRise && (bitCnt == 3'd7);
    assign boundary = (bitCnt == 3'd0);

    always_ff @(posedge sys_clk) begin
        if (reset || csFall) begin
            bitCnt  <= 3'd0;
            shiftIn <= 8'h00;
        end else if (clkRise) begin
            bitCnt  <= bitCnt + 3'd1;
            shiftIn <= rxByte;
        end
    end

    assign busy = (engine != EN_IDLE);

    always_comb begin
        next_op    = OP_NONE;
        next_phase = PH_IGNORE;
        if (busy) begin
            if (rxByte == OPC_STATUS_FETCH) begin
                next_op    = OP_FETCH_STATUS;
                next_phase = PH_GIVE;
            end else if (rxByte == OPC_DISABLE_WRITES) begin
                next_op = OP_WDIS;
            end
        end else begin
            case (rxByte)
                OPC_ENABLE_WRITES: begin
                    next_op = OP_WEN;
                end
                OPC_DISABLE_WRITES: begin
                    next_op = OP_WDIS;
                end
                OPC_STATUS_FETCH: begin
                    next_op    = OP_FETCH_STATUS;
                    next_phase = PH_GIVE;
                end
                OPC_ARRAY_READ: begin
                    next_op    = OP_FETCH_ARRAY;
                    next_phase = PH_ADDR_HI;
                end
                OPC_IDPAGE_FETCH: begin
                    next_op    = OP_FETCH_ID;
                    next_phase = PH_ADDR_HI;
                end
                OPC_STATUS_STORE: begin
                    if (write_enable_latch) begin
                        next_op    = OP_STATUS;
                        next_phase = PH_TAKE;
                    end
                end
                OPC_ARRAY_WRITE: begin
                    if (write_enable_latch) begin
                        next_op    = OP_ARRAY;
                        next_phase = PH_ADDR_HI;
                    end
                end
                OPC_IDPAGE_STORE: begin
                    if (write_enable_latch) begin
                        next_op    = OP_IDPAGE;
                        next_phase = PH_ADDR_HI;
                    end
                end
                default: begin
                    next_op = OP_NONE;
                end
            endcase
        end
    end

    assign opIsFetch = (op == OP_FETCH_ARRAY) || (op == OP_FETCH_ID);
    assign addrNext  = (op == OP_FETCH_ID) ? {9'h000, addr[6:0] + 7'h01} : addr + 16'h0001;

    always_ff @(posedge sys_clk) begin
        if (reset || csFall) begin
            phase      <= PH_OPCODE;
            op         <= OP_NONE;
            addr       <= 16'h0000;
            gotData    <= 1'b0;
            stagedByte <= 8'h00;
        end else if (byteDone) begin
            unique case (phase)
                PH_OPCODE: begin
                    phase <= next_phase;
                    op    <= next_op;
                end
                PH_ADDR_HI: begin
                    addr[15:8] <= rxByte;
                    phase      <= PH_ADDR_LO;
                end
                PH_ADDR_LO: begin
                    addr[7:0] <= rxByte;
                    phase     <= opIsFetch ? PH_GIVE : PH_TAKE;
                end
                PH_TAKE: begin
                    gotData    <= 1'b1;
                    stagedByte <= rxByte;
                end
                PH_GIVE: begin
                    addr <= addrNext;
                end
                PH_IGNORE: begin
                    phase <= PH_IGNORE;
                end
            endcase
        end
    end

    assign issueGive = byteDone && ((phase == PH_OPCODE && next_phase == PH_GIVE)
                                 || (phase == PH_ADDR_LO && opIsFetch)
                                 || (phase == PH_GIVE));

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            loadPending <= 1'b0;
        end else begin
            loadPending <= issueGive;
        end
    end

    assign statusByte = '{statusWriteDisable: swd, unused: 3'b000,
                          blockProtectHi: bp[1], blockProtectLo: bp[0],
                          writeEnableLatch: write_enable_latch, busyFlag: busy};

    always_comb begin
        if (op == OP_FETCH_STATUS) begin
            outByte = statusByte;
        end else if (op == OP_FETCH_ID && addr[LOCK_SEL_BIT]) begin
            outByte = 8'h00;
        end else begin
            outByte = memQ;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || csFall) begin
            outShift <= 8'h00;
            dataOut  <= 1'b0;
            outLive  <= 1'b0;
        end else if (loadPending) begin
            outShift <= outByte;
        end else if (clkFall && phase == PH_GIVE) begin
            dataOut  <= outShift[7];
            outShift <= {outShift[6:0], 1'b0};
            outLive  <= 1'b1;
        end
    end

    assign dataOutEn = outLive && inFrame && !paused && !pinSync.chipSelN;

    always_comb begin
        blocked = 1'b0;
        if (op == OP_STATUS) begin
            blocked = swd && !pinSync.writeProtN;
        end else if (op == OP_IDPAGE) begin
            blocked = (bp == BP_ALL);
        end else begin
            unique case (bp)
                BP_NONE:    blocked = 1'b0;
                BP_QUARTER: blocked = (addr >= PROT_QUARTER_BASE);
                BP_HALF:    blocked = (addr >= PROT_HALF_BASE);
                BP_ALL:     blocked = 1'b1;
            endcase
        end
    end

    assign validEnd    = csRise && inFrame && !paused && boundary;
    assign commitWrite = validEnd && phase == PH_TAKE && gotData && !blocked && !busy
                         && (op == OP_STATUS || op == OP_ARRAY || op == OP_IDPAGE);
    assign discard     = csRise && !commitWrite;

    // Only data bytes of array or page writes enter the buffer
    assign fifoInValid  = byteDone && phase == PH_TAKE && (op == OP_ARRAY || op == OP_IDPAGE);
    assign fifoOutReady = (engine == EN_PROGRAM);

    epr_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .flush    (discard),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (rxByte),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOutData)
    );

    assign cycleDone = (engine == EN_SETTLE) && (timer >= 32'(PROG_CYCLES - 1));

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            engine     <= EN_IDLE;
            progOp     <= OP_NONE;
            progAddr   <= 16'h0000;
            progLock   <= 1'b0;
            progStatus <= 8'h00;
            timer      <= 32'd0;
        end else begin
            unique case (engine)
                EN_IDLE: begin
                    timer <= 32'd0;
                    if (commitWrite) begin
                        progOp     <= op;
                        progAddr   <= addr;
                        progLock   <= (op == OP_IDPAGE) && addr[LOCK_SEL_BIT];
                        progStatus <= stagedByte;
                        engine     <= (op == OP_STATUS) ? EN_SETTLE : EN_PROGRAM;
                    end
                end
                EN_PROGRAM: begin
                    timer <= timer + 32'd1;
                    if (fifoOutValid) begin
                        progAddr[6:0] <= progAddr[6:0] + 7'h01;
                    end else begin
                        engine <= EN_SETTLE;
                    end
                end
                EN_SETTLE: begin
                    timer <= timer + 32'd1;
                    if (cycleDone) begin
                        engine <= EN_IDLE;
                    end
                end
                default: begin
                    engine <= EN_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            write_enable_latch <= 1'b0;
        end else if (cycleDone) begin
            write_enable_latch <= 1'b0;
        end else if (validEnd && phase == PH_IGNORE && op == OP_WDIS) begin
            write_enable_latch <= 1'b0;
        end else if (validEnd && phase == PH_IGNORE && op == OP_WEN) begin
            write_enable_latch <= 1'b1;
        end
    end

    // protect bits only by status store
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bp  <= BP_RESET;
            swd <= SWD_RESET;
        end else if (cycleDone && progOp == OP_STATUS) begin
            bp  <= {progStatus[3], progStatus[2]};
            swd <= progStatus[7];
        end
    end

    always_comb begin
        memReq       = '0;
        memReq.wdata = fifoOutData;
        if (busy) begin
            memReq.wr    = (engine == EN_PROGRAM) && fifoOutValid && !progLock;
            memReq.idSel = (progOp == OP_IDPAGE);
            memReq.addr  = progAddr;
        end else begin
            memReq.rd    = issueGive;
            memReq.idSel = (op == OP_FETCH_ID);
            memReq.addr  = (phase == PH_ADDR_LO) ? {addr[15:8], rxByte} : addrNext;
        end
    end

    epr_byte_store u_store (
        .sys_clk (sys_clk),
        .reset   (reset),
        .req     (memReq),
        .rdData  (memQ)
    );

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            standby <= 1'b1;
        end else begin
            standby <= !inFrame && !busy;
        end
    end

endmodule
`default_nettype wire
